// file: common/tcf_pkg.sv
package tcf_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register port geometry
  localparam int unsigned ADDR_W = 6;   // Serial port register address width
  localparam int unsigned DATA_W = 16;  // Register word width
  localparam int unsigned BYTE_W = 8;   // Queue byte width
  localparam int unsigned DAC_W  = 6;   // DAC sample width per branch
  localparam int unsigned NSRC   = 8;   // Number of DAC data sources
  localparam int unsigned NROUTE = 9;   // Number of analog routing codes

  //////////////////////////////////////////////////////////////////////////////
  // Register addresses
  localparam logic [ADDR_W-1:0] ADDR_DAC_TEST  = 6'h2E;  // dac_test_control
  localparam logic [ADDR_W-1:0] ADDR_TOP_TEST  = 6'h2F;  // top_level_test_control
  localparam logic [ADDR_W-1:0] ADDR_SPARE     = 6'h30;  // spare_control_status
  localparam logic [ADDR_W-1:0] ADDR_TXQ_PORT  = 6'h3E;  // transmit_queue_byte_port
  localparam logic [ADDR_W-1:0] ADDR_RXQ_PORT  = 6'h3F;  // receive_queue_byte_port

  //////////////////////////////////////////////////////////////////////////////
  // dac_test_reg field positions
  localparam int unsigned DAC_SOURCE_SELECT_LSB = 12;  // dac_source_select [14:12]
  localparam int unsigned DAC_I_LSB   = 6;   // I override [11:6]
  localparam int unsigned DAC_Q_LSB   = 0;   // Q override [5:0]

  // top_test_reg field positions
  localparam int unsigned TOP_BIST_BIT = 7;  // memory_selftest_run
  localparam int unsigned TOP_BATT_BIT = 6;  // battery_monitor_test_out
  localparam int unsigned TOP_VC_BIT   = 5;  // vc_node_drive_enable
  localparam int unsigned TOP_PD_BIT   = 4;  // analog_test_powerdown
  localparam int unsigned TOP_MODE_LSB = 0;  // analog_test_route_sel [3:0]

  //////////////////////////////////////////////////////////////////////////////
  // Codes
  localparam logic [2:0] DAC_SOURCE_SELECT_MOD      = 3'h0;  // Modulator
  localparam logic [2:0] DAC_SOURCE_SELECT_OVERRIDE = 3'h1;  // Override values
  localparam logic [3:0] ROUTE_VC_NODE    = 4'h7;  // IF loop and VC node access
  localparam logic [3:0] ROUTE_LAST       = 4'h8;  // Highest valid routing code

  //////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [2:0]        RST_DAC_SOURCE_SELECT = 3'h0;
  localparam logic [DAC_W-1:0]  RST_DAC_OVR = 6'h00;
  localparam logic              RST_BIST    = 1'b0;
  localparam logic              RST_BATT    = 1'b0;
  localparam logic              RST_VC      = 1'b0;
  localparam logic              RST_PD      = 1'b1;
  localparam logic [3:0]        RST_MODE    = 4'h0;
  localparam logic [DATA_W-1:0] RST_SPARE   = 16'h0000;
  localparam logic [BYTE_W-1:0] RST_BYTE    = 8'h00;

  //////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned READ_LATENCY = 1;  // Cycles from read strobe to data

endpackage

// file: rtl/tcf_skid_buf.sv
`timescale 1ns/1ps
module tcf_skid_buf (
  input  wire logic                       i_core_clk,
  input  wire logic                       i_rst_b,
  input  wire logic                       i_in_valid,
  input  wire logic [tcf_pkg::BYTE_W-1:0] i_in_data,
  output logic                            o_in_ready,
  output logic                            o_out_valid,
  output logic [tcf_pkg::BYTE_W-1:0]      o_out_data,
  input  wire logic                       i_out_ready
);

  //////////////////////////////////////////////////////////////////////////////
  // State of the two-entry buffer
  typedef struct packed {
    logic [tcf_pkg::BYTE_W-1:0] head;   // Oldest byte
    logic [tcf_pkg::BYTE_W-1:0] tail;   // Second byte
    logic                       valid;  // Head holds a byte
    logic                       full;   // Both entries held
  } tcf_buf_s;

  tcf_buf_s st_r;    // Registered state
  tcf_buf_s st_nxt;  // Next state
  logic     push;    // Byte accepted
  logic     pop;     // Byte drained

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_nxt = st_r;
    push   = i_in_valid & ~st_r.full;
    pop    = st_r.valid & i_out_ready;
    if (!st_r.valid) begin
      // Empty
      if (push) begin
        st_nxt.head  = i_in_data;
        st_nxt.valid = 1'b1;
      end
    end else if (!st_r.full) begin
      // One entry
      if (push && pop) begin
        st_nxt.head = i_in_data;
      end else if (pop) begin
        st_nxt.valid = 1'b0;
      end else if (push) begin
        st_nxt.tail = i_in_data;
        st_nxt.full = 1'b1;
      end
    end else if (pop) begin
      // Full, shift tail forward
      st_nxt.head = st_r.tail;
      st_nxt.full = 1'b0;
    end
  end

  // State register
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_in_ready  = ~st_r.full;
  assign o_out_valid = st_r.valid;
  assign o_out_data  = st_r.head;

endmodule

// file: rtl/tcf_regs.sv
`timescale 1ns/1ps
module tcf_regs (
  input  wire logic                                  i_core_clk,
  input  wire logic                                  i_rst_b,
  input  wire logic [tcf_pkg::ADDR_W-1:0]            i_reg_addr,
  input  wire logic                                  i_reg_wr,
  input  wire logic                                  i_reg_rd,
  input  wire logic [tcf_pkg::DATA_W-1:0]            i_reg_wdata,
  output logic [tcf_pkg::DATA_W-1:0]                 o_reg_rdata,
  output logic                                       o_reg_rvalid,
  input  wire logic                                  i_xosc_running,
  input  wire logic [tcf_pkg::NSRC*tcf_pkg::DAC_W-1:0] i_dac_source_select_i,
  input  wire logic [tcf_pkg::NSRC*tcf_pkg::DAC_W-1:0] i_dac_source_select_q,
  output logic [tcf_pkg::DAC_W-1:0]                  o_dac_i,
  output logic [tcf_pkg::DAC_W-1:0]                  o_dac_q,
  output logic [2:0]                                 o_dac_source_select,
  input  wire logic                                  i_selftest_result,
  output logic                                       o_memory_selftest_run,
  output logic                                       o_selftest_result_out,
  output logic                                       o_battery_monitor_test_out,
  output logic                                       o_analog_test_powerdown,
  output logic [tcf_pkg::NROUTE-1:0]                 o_analog_route_en,
  output logic                                       o_vc_node_drive,
  output logic                                       o_vc_node_sense,
  output logic                                       o_txq_valid,
  output logic [tcf_pkg::BYTE_W-1:0]                 o_txq_data,
  input  wire logic                                  i_txq_ready,
  output logic                                       o_tx_port_ready,
  input  wire logic                                  i_rxq_valid,
  input  wire logic [tcf_pkg::BYTE_W-1:0]            i_rxq_data,
  output logic                                       o_rxq_pop,
  output logic                                       o_rxq_wr_valid,
  output logic [tcf_pkg::BYTE_W-1:0]                 o_rxq_wr_data
);

  //////////////////////////////////////////////////////////////////////////////
  // All state of the register bank
  typedef struct packed {
    logic [2:0]                   dac_source_select;     // dac_source_select
    logic [tcf_pkg::DAC_W-1:0]    dac_i_ovr;   // I override value
    logic [tcf_pkg::DAC_W-1:0]    dac_q_ovr;   // Q override value
    logic                         bist_run;    // memory_selftest_run
    logic                         batt_test;   // battery_monitor_test_out
    logic                         vc_en;       // vc_node_drive_enable
    logic                         atest_pd;    // analog_test_powerdown
    logic [3:0]                   atest_mode;  // analog_test_route_sel
    logic [tcf_pkg::DATA_W-1:0]   spare;       // spare_bits
    logic [tcf_pkg::DATA_W-1:0]   rdata;       // Read answer
    logic                         rvalid;      // Read answer strobe
    logic [tcf_pkg::DAC_W-1:0]    dac_i;       // I DAC sample
    logic [tcf_pkg::DAC_W-1:0]    dac_q;       // Q DAC sample
    logic                         bist_out;    // Selftest result on pin
    logic [tcf_pkg::NROUTE-1:0]   route_en;    // Active analog route
    logic                         vc_drive;    // Pin drives VC node
    logic                         vc_sense;    // Pin outputs VC node
    logic                         rxq_pop;     // Receive byte taken
    logic                         rxw_valid;   // Receive byte written
    logic [tcf_pkg::BYTE_W-1:0]   rxw_data;    // Receive byte written value
    logic                         xosc_s1;     // Oscillator sync stage one
    logic                         xosc_s2;     // Oscillator sync stage two
  } tcf_regs_s;

  tcf_regs_s                  st_r;       // Registered state
  tcf_regs_s                  st_nxt;     // Next state
  logic                       tx_push;    // Byte offered to buffer
  logic                       buf_ready;  // Buffer can take a byte
  logic [tcf_pkg::BYTE_W-1:0] tx_byte;    // Byte offered to buffer

  //////////////////////////////////////////////////////////////////////////////
  // Decode helpers
  // Pick one DAC feed, override slot replaced by register value
  function automatic logic [tcf_pkg::DAC_W-1:0] dac_pick(
    input logic [2:0]                                 sel,
    input logic [tcf_pkg::NSRC*tcf_pkg::DAC_W-1:0]    feeds,
    input logic [tcf_pkg::DAC_W-1:0]                  ovr
  );
    if (sel == tcf_pkg::DAC_SOURCE_SELECT_OVERRIDE) begin
      dac_pick = ovr;
    end else begin
      dac_pick = feeds[sel*tcf_pkg::DAC_W +: tcf_pkg::DAC_W];
    end
  endfunction

  // One-hot route, empty while powered down or code out of range
  function automatic logic [tcf_pkg::NROUTE-1:0] route_onehot(
    input logic       pd,
    input logic [3:0] mode
  );
    route_onehot = '0;
    if (!pd && (mode <= tcf_pkg::ROUTE_LAST)) begin
      route_onehot[mode] = 1'b1;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_nxt           = st_r;
    st_nxt.rvalid    = 1'b0;
    st_nxt.rxq_pop   = 1'b0;
    st_nxt.rxw_valid = 1'b0;
    tx_push          = 1'b0;
    tx_byte          = i_reg_wdata[tcf_pkg::BYTE_W-1:0];

    // Oscillator level synchroniser
    st_nxt.xosc_s1 = i_xosc_running;
    st_nxt.xosc_s2 = st_r.xosc_s1;

    // Register writes; reserved bits are not stored
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        tcf_pkg::ADDR_DAC_TEST: begin
          st_nxt.dac_source_select   = i_reg_wdata[tcf_pkg::DAC_SOURCE_SELECT_LSB +: 3];
          st_nxt.dac_i_ovr = i_reg_wdata[tcf_pkg::DAC_I_LSB +: tcf_pkg::DAC_W];
          st_nxt.dac_q_ovr = i_reg_wdata[tcf_pkg::DAC_Q_LSB +: tcf_pkg::DAC_W];
        end
        tcf_pkg::ADDR_TOP_TEST: begin
          st_nxt.bist_run   = i_reg_wdata[tcf_pkg::TOP_BIST_BIT];
          st_nxt.batt_test  = i_reg_wdata[tcf_pkg::TOP_BATT_BIT];
          st_nxt.vc_en      = i_reg_wdata[tcf_pkg::TOP_VC_BIT];
          st_nxt.atest_pd   = i_reg_wdata[tcf_pkg::TOP_PD_BIT];
          st_nxt.atest_mode = i_reg_wdata[tcf_pkg::TOP_MODE_LSB +: 4];
        end
        tcf_pkg::ADDR_SPARE: begin
          st_nxt.spare = i_reg_wdata;
        end
        tcf_pkg::ADDR_TXQ_PORT: begin
          // Dropped while the oscillator is stopped
          tx_push = st_r.xosc_s2;
        end
        tcf_pkg::ADDR_RXQ_PORT: begin
          // Receive byte written toward the queue logic
          st_nxt.rxw_valid = st_r.xosc_s2;
          st_nxt.rxw_data  = i_reg_wdata[tcf_pkg::BYTE_W-1:0];
        end
        default: begin
          // Unmapped, ignored
        end
      endcase
    end

    // Register reads, answered one cycle later
    if (i_reg_rd) begin
      st_nxt.rvalid = 1'b1;
      unique case (i_reg_addr)
        tcf_pkg::ADDR_DAC_TEST: begin
          st_nxt.rdata = {1'b0, st_r.dac_source_select, st_r.dac_i_ovr, st_r.dac_q_ovr};
        end
        tcf_pkg::ADDR_TOP_TEST: begin
          st_nxt.rdata = {8'h00, st_r.bist_run, st_r.batt_test, st_r.vc_en,
                          st_r.atest_pd, st_r.atest_mode};
        end
        tcf_pkg::ADDR_SPARE: begin
          st_nxt.rdata = st_r.spare;
        end
        tcf_pkg::ADDR_TXQ_PORT: begin
          // Write-only port, contents never returned
          st_nxt.rdata = 16'h0000;
        end
        tcf_pkg::ADDR_RXQ_PORT: begin
          // Pop a byte only when one is there and the clock runs
          if (i_rxq_valid && st_r.xosc_s2) begin
            st_nxt.rdata   = {8'h00, i_rxq_data};
            st_nxt.rxq_pop = 1'b1;
          end else begin
            st_nxt.rdata = 16'h0000;
          end
        end
        default: begin
          // Unmapped reads as zero
          st_nxt.rdata = 16'h0000;
        end
      endcase
    end

    // DAC data path
    st_nxt.dac_i = dac_pick(st_r.dac_source_select, i_dac_source_select_i, st_r.dac_i_ovr);
    st_nxt.dac_q = dac_pick(st_r.dac_source_select, i_dac_source_select_q, st_r.dac_q_ovr);

    // Selftest result only while the test runs
    st_nxt.bist_out = st_r.bist_run & i_selftest_result;

    // Analog test routing
    st_nxt.route_en = route_onehot(st_r.atest_pd, st_r.atest_mode);
    st_nxt.vc_drive = !st_r.atest_pd && (st_r.atest_mode == tcf_pkg::ROUTE_VC_NODE)
                      && st_r.vc_en;
    st_nxt.vc_sense = !st_r.atest_pd && (st_r.atest_mode == tcf_pkg::ROUTE_VC_NODE)
                      && !st_r.vc_en;
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      st_r            <= '0;
      st_r.dac_source_select    <= tcf_pkg::RST_DAC_SOURCE_SELECT;
      st_r.dac_i_ovr  <= tcf_pkg::RST_DAC_OVR;
      st_r.dac_q_ovr  <= tcf_pkg::RST_DAC_OVR;
      st_r.bist_run   <= tcf_pkg::RST_BIST;
      st_r.batt_test  <= tcf_pkg::RST_BATT;
      st_r.vc_en      <= tcf_pkg::RST_VC;
      st_r.atest_pd   <= tcf_pkg::RST_PD;
      st_r.atest_mode <= tcf_pkg::RST_MODE;
      st_r.spare      <= tcf_pkg::RST_SPARE;
      st_r.rxw_data   <= tcf_pkg::RST_BYTE;
    end else begin
      st_r <= st_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmit byte buffer, stalls under receiver back-pressure
  tcf_skid_buf u_tx_buf (
    .i_core_clk  (i_core_clk),
    .i_rst_b     (i_rst_b),
    .i_in_valid  (tx_push),
    .i_in_data   (tx_byte),
    .o_in_ready  (buf_ready),
    .o_out_valid (o_txq_valid),
    .o_out_data  (o_txq_data),
    .i_out_ready (i_txq_ready)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign o_reg_rdata                = st_r.rdata;
  assign o_reg_rvalid               = st_r.rvalid;
  assign o_dac_i                    = st_r.dac_i;
  assign o_dac_q                    = st_r.dac_q;
  assign o_dac_source_select        = st_r.dac_source_select;
  assign o_memory_selftest_run      = st_r.bist_run;
  assign o_selftest_result_out      = st_r.bist_out;
  assign o_battery_monitor_test_out = st_r.batt_test;
  assign o_analog_test_powerdown    = st_r.atest_pd;
  assign o_analog_route_en          = st_r.route_en;
  assign o_vc_node_drive            = st_r.vc_drive;
  assign o_vc_node_sense            = st_r.vc_sense;
  assign o_tx_port_ready            = buf_ready;
  assign o_rxq_pop                  = st_r.rxq_pop;
  assign o_rxq_wr_valid             = st_r.rxw_valid;
  assign o_rxq_wr_data              = st_r.rxw_data;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_dac_ovr;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (st_r.dac_source_select == tcf_pkg::DAC_SOURCE_SELECT_OVERRIDE) |=>
      (o_dac_i == $past(st_r.dac_i_ovr)) && (o_dac_q == $past(st_r.dac_q_ovr));
  endproperty
  a_dac_ovr: assert property (p_dac_ovr) else $error("override not on DACs");

  property p_dac_mod;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (st_r.dac_source_select == tcf_pkg::DAC_SOURCE_SELECT_MOD) |=> (o_dac_i == $past(i_dac_source_select_i[5:0]));
  endproperty
  a_dac_mod: assert property (p_dac_mod) else $error("modulator not on DAC");

  property p_pd_reset;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    $rose(i_rst_b) |-> o_analog_test_powerdown && (o_analog_route_en == 9'h000);
  endproperty
  a_pd_reset: assert property (p_pd_reset) else $error("not powered down at reset");

  property p_route_off;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    st_r.atest_pd |=> (o_analog_route_en == 9'h000) && !o_vc_node_drive;
  endproperty
  a_route_off: assert property (p_route_off) else $error("route active in powerdown");

  property p_route_on;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (!st_r.atest_pd && (st_r.atest_mode == 4'h4)) |=> (o_analog_route_en == 9'h010);
  endproperty
  a_route_on: assert property (p_route_on) else $error("route four not selected");

  property p_vc_drive;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (!st_r.atest_pd && (st_r.atest_mode == 4'h7)) |=>
      (o_vc_node_drive == $past(st_r.vc_en)) && (o_vc_node_sense != $past(st_r.vc_en));
  endproperty
  a_vc_drive: assert property (p_vc_drive) else $error("VC node use wrong");

  property p_bist;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    !st_r.bist_run |=> !o_selftest_result_out;
  endproperty
  a_bist: assert property (p_bist) else $error("selftest result leaks");

  property p_spare_rb;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (i_reg_wr && (i_reg_addr == 6'h30)) ##1 (i_reg_rd && !i_reg_wr && (i_reg_addr == 6'h30))
      |=> o_reg_rvalid && (o_reg_rdata == $past(i_reg_wdata, 2));
  endproperty
  a_spare_rb: assert property (p_spare_rb) else $error("spare readback wrong");

  property p_tx_noread;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (i_reg_rd && (i_reg_addr == 6'h3E)) |=> o_reg_rvalid && (o_reg_rdata == 16'h0000);
  endproperty
  a_tx_noread: assert property (p_tx_noread) else $error("transmit port readable");

  property p_tx_push;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (i_reg_wr && (i_reg_addr == 6'h3E) && st_r.xosc_s2 && buf_ready) |=> o_txq_valid;
  endproperty
  a_tx_push: assert property (p_tx_push) else $error("transmit byte lost");

  property p_rx_read;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (i_reg_rd && (i_reg_addr == 6'h3F) && i_rxq_valid && st_r.xosc_s2) |=>
      o_rxq_pop && (o_reg_rdata[7:0] == $past(i_rxq_data));
  endproperty
  a_rx_read: assert property (p_rx_read) else $error("receive byte not read");

  c_override: cover property (@(posedge i_core_clk) st_r.dac_source_select == 3'h1);
  c_tx_full: cover property (@(posedge i_core_clk) !buf_ready ##1 buf_ready);
  c_vc_drive: cover property (@(posedge i_core_clk) o_vc_node_drive);
  c_rx_pop: cover property (@(posedge i_core_clk) o_rxq_pop ##2 o_rxq_pop);

endmodule

// file: bench/tcf_queue_model.sv
`timescale 1ns/1ps
// Far side of the queues: transmit sink with stall, two-byte receive source
module tcf_queue_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_stall,
  input  wire logic        i_txq_valid,
  input  wire logic [7:0]  i_txq_data,
  output logic             o_txq_ready,
  input  wire logic        i_rxq_pop,
  output logic             o_rxq_valid,
  output logic [7:0]       o_rxq_data,
  output logic [3:0]       o_tx_cnt,
  output logic [15:0]      o_tx_log
);
  logic [1:0] rx_idx;  // Bytes popped so far
  // Sink stalls on request
  assign o_txq_ready = !i_stall;
  // Empty head shows a filler byte, never the last real one
  assign o_rxq_valid = (rx_idx < 2'h2);
  assign o_rxq_data  = o_rxq_valid ? (8'hA0 + {6'h00, rx_idx}) : 8'h5E;
  // Pop bookkeeping and transmit byte log, newest byte low
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      rx_idx   <= 2'h0;
      o_tx_cnt <= 4'h0;
      o_tx_log <= 16'h0000;
    end else begin
      if (i_rxq_pop) begin
        rx_idx <= rx_idx + 2'h1;
      end
      if (i_txq_valid && o_txq_ready) begin
        o_tx_cnt <= o_tx_cnt + 4'h1;
        o_tx_log <= {o_tx_log[7:0], i_txq_data};
      end
    end
  end
endmodule

// file: bench/test_tcf_regs.sv
`timescale 1ns/1ps
module test_tcf_regs;
  logic        i_core_clk, i_rst_b, i_reg_wr, i_reg_rd, stall, o_reg_rvalid;
  logic [5:0]  i_reg_addr, o_dac_i, o_dac_q;
  logic [15:0] i_reg_wdata, o_reg_rdata, tx_log;
  logic [47:0] src_i, src_q;
  logic [2:0]  dac_sel;
  logic        run, res_out, batt, pd, vc_drv, vc_sns, txq_valid, txq_ready;
  logic        tx_port_ready, rxq_valid, rxq_pop, rxq_wr_valid;
  logic [8:0]  route;
  logic [7:0]  txq_data, rxq_data, rxq_wr_data;
  logic [3:0]  tx_cnt;
  logic        xosc, sres;
  int          mismatches, total_checks, cycles;
  // Oscillator runs except in one refusal test; selftest result is bench driven
  tcf_regs DUT (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_xosc_running(xosc),
    .i_dac_source_select_i(src_i), .i_dac_source_select_q(src_q), .o_dac_i(o_dac_i), .o_dac_q(o_dac_q),
    .o_dac_source_select(dac_sel), .i_selftest_result(sres), .o_memory_selftest_run(run),
    .o_selftest_result_out(res_out), .o_battery_monitor_test_out(batt),
    .o_analog_test_powerdown(pd), .o_analog_route_en(route), .o_vc_node_drive(vc_drv),
    .o_vc_node_sense(vc_sns), .o_txq_valid(txq_valid), .o_txq_data(txq_data),
    .i_txq_ready(txq_ready), .o_tx_port_ready(tx_port_ready), .i_rxq_valid(rxq_valid),
    .i_rxq_data(rxq_data), .o_rxq_pop(rxq_pop), .o_rxq_wr_valid(rxq_wr_valid),
    .o_rxq_wr_data(rxq_wr_data));
  tcf_queue_model u_model (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_stall(stall),
    .i_txq_valid(txq_valid), .i_txq_data(txq_data), .o_txq_ready(txq_ready),
    .i_rxq_pop(rxq_pop), .o_rxq_valid(rxq_valid), .o_rxq_data(rxq_data),
    .o_tx_cnt(tx_cnt), .o_tx_log(tx_log));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Compare, register write and register read
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(negedge i_core_clk);
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(negedge i_core_clk);
    i_reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] exp);
    @(negedge i_core_clk);
    i_reg_rd = 1'b1;
    i_reg_addr = a;
    @(negedge i_core_clk);
    i_reg_rd = 1'b0;
    check("read valid", 16'h0001, {15'h0000, o_reg_rvalid});
    check("read data", exp, o_reg_rdata);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    {i_rst_b, i_reg_wr, i_reg_rd, stall} = 4'h0;
    {xosc, sres} = 2'b11;
    i_reg_addr = 6'h00;
    i_reg_wdata = 16'h0000;
    for (int k = 0; k < 8; k++) begin
      src_i[6*k +: 6] = 6'(k + 16);
      src_q[6*k +: 6] = 6'(k + 32);
    end
    repeat (3) @(negedge i_core_clk);
    i_rst_b = 1'b1;
    repeat (3) @(negedge i_core_clk);
    check("powerdown", 16'h0001, {15'h0000, pd});
    check("route", 16'h0000, {7'h00, route});
    rd(tcf_pkg::ADDR_DAC_TEST, 16'h0000);
    rd(tcf_pkg::ADDR_TOP_TEST, 16'h0010);
    rd(tcf_pkg::ADDR_SPARE, 16'h0000);
    $display("reset test done");
    wr(6'h30, 16'hA5C3);
    rd(6'h30, 16'hA5C3);
    rd(6'h31, 16'h0000);
    // Write then read back to back
    @(negedge i_core_clk);
    {i_reg_wr, i_reg_addr, i_reg_wdata} = {1'b1, 6'h30, 16'h5A3C};
    @(negedge i_core_clk);
    {i_reg_wr, i_reg_rd} = 2'b01;
    @(negedge i_core_clk);
    i_reg_rd = 1'b0;
    check("spare back to back", 16'h5A3C, o_reg_rdata);
    $display("spare test done");
    // Analog test powered up on route four for DAC sources
    wr(6'h2F, 16'h0004);
    // Every source code, reserved bit kept zero
    for (int s = 0; s < 8; s++) begin
      wr(6'h2E, {1'b0, 3'(s), 12'hA95});
      repeat (2) @(negedge i_core_clk);
      check("dac select", 16'(s), {13'h0000, dac_sel});
      check("dac i", (s == 1) ? 16'h002A : 16'(s + 16), {10'h000, o_dac_i});
      check("dac q", (s == 1) ? 16'h0015 : 16'(s + 32), {10'h000, o_dac_q});
      rd(6'h2E, {1'b0, 3'(s), 12'hA95});
    end
    $display("dac test done");
    // Every routing code, powered up, all flags set
    for (int m = 0; m < 16; m++) begin
      wr(6'h2F, {8'h00, 4'hE, 4'(m)});
      repeat (2) @(negedge i_core_clk);
      check("route", (m < 9) ? 16'(1 << m) : 16'h0000, {7'h00, route});
      check("vc drive", 16'(m == 7), {15'h0000, vc_drv});
      check("flags", 16'h0007, {13'h0000, run, batt, res_out});
    end
    rd(6'h2F, 16'h00EF);
    // Selftest result follows the result input while running
    sres = 1'b0;
    repeat (2) @(negedge i_core_clk);
    check("selftest out", 16'h0002, {14'h0000, run, res_out});
    sres = 1'b1;
    wr(6'h2F, 16'h0007);
    repeat (2) @(negedge i_core_clk);
    check("sense", 16'h0008, {12'h000, vc_sns, vc_drv, run, res_out});
    wr(6'h2F, 16'h0037);
    repeat (2) @(negedge i_core_clk);
    check("powered down", 16'h0001, {5'h00, route, vc_drv, pd});
    $display("top test done");
    // Receiver stalls; third byte finds the buffer full
    stall = 1'b1;
    wr(6'h3E, 16'hFF11);
    wr(6'h3E, 16'h0022);
    wr(6'h3E, 16'h0033);
    check("port ready", 16'h0000, {15'h0000, tx_port_ready});
    rd(6'h3E, 16'h0000);
    stall = 1'b0;
    repeat (4) @(negedge i_core_clk);
    check("tx count", 16'h0002, {12'h000, tx_cnt});
    check("tx order", 16'h1122, tx_log);
    $display("transmit test done");
    // Oscillator stopped: port accesses refused, no pop
    xosc = 1'b0;
    repeat (3) @(negedge i_core_clk);
    rd(6'h3F, 16'h0000);
    wr(6'h3E, 16'h0044);
    wr(6'h3F, 16'h0077);
    check("rx write off", 16'h0000, {15'h0000, rxq_wr_valid});
    check("tx count off", 16'h0002, {12'h000, tx_cnt});
    xosc = 1'b1;
    repeat (3) @(negedge i_core_clk);
    rd(6'h3F, 16'h00A0);
    rd(6'h3F, 16'h00A1);
    rd(6'h3F, 16'h0000);
    wr(6'h3F, 16'hAB5A);
    check("rx write", 16'h015A, {7'h00, rxq_wr_valid, rxq_wr_data});
    $display("receive test done");
    finish_test();
  end
endmodule
